// file: sim/ccr_host_model.sv
// host side of the register port, one byte per access
// assumes the bank answers a read one edge after taking it
`timescale 1ns/10ps
module ccr_host_model
  import ccr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rvalid_in,
  input wire logic [7:0] rdata_in,
  output ccr_req_s req_out
);
  initial req_out = '0; // idle until asked
  // write strobe held for the one edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '0;
  endtask
  // read strobe; answer sampled at the following edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    req_out <= '0;
    @(posedge clk_in);
    ok = rvalid_in;
    d = rdata_in;
  endtask
endmodule

// file: sim/ccr_regs_checker.sv
// checker for the charger register bank, bound into ccr_regs
// assumes one clock domain and an async active-low reset
`timescale 1ns/10ps
module ccr_regs_checker
  import ccr_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire ccr_req_s req_in,
  input wire logic [7:0] rdata_out,
  input wire logic finish_current_cutoff_on_out,
  input wire logic battery_detect_run_out,
  input wire logic charger_on_out,
  input wire logic spread_spectrum_on_out,
  input wire logic soft_reset_out,
  input wire ccr_set_s setpoints_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // soft reset command on the request port
  logic srst_req;
  assign srst_req = req_in.wr && req_in.addr == OFS_SOFT_RST && req_in.wdata[7];
  // write taken, then two edges until derived outputs settle
  sequence s_wr(logic [7:0] a);
    req_in.wr && req_in.addr == a ##2 1'b1;
  endsequence
  AST_SRST_READ: assert property (req_in.rd && req_in.addr == OFS_SOFT_RST |=> !rdata_out[7])
    else $error("reset bit read as one");
  AST_SRST_PULSE: assert property (srst_req |-> ##[1:2] soft_reset_out)
    else $error("reset pulse missing");
  AST_SRST_SHORT: assert property (soft_reset_out |=> !soft_reset_out)
    else $error("reset pulse too long");
  AST_EOC: assert property (s_wr(OFS_TERM_MODE) |->
    setpoints_out.eoc_ma == 12'd100 + 12'd50 * $past(req_in.wdata[7:5], 2)) else $error("end current wrong");
  AST_TERM: assert property (s_wr(OFS_TERM_MODE) |->
    finish_current_cutoff_on_out == $past(req_in.wdata[3], 2)) else $error("termination wrong");
  AST_FLOOR: assert property (s_wr(OFS_SYS_PREC) |->
    setpoints_out.sysmin_mv == 12'd3500 + 12'd100 * $past(req_in.wdata[5:4], 2)) else $error("floor wrong");
  AST_PREC: assert property (s_wr(OFS_SYS_PREC) |->
    setpoints_out.prec_ma == 12'd100 + 12'd50 * $past(req_in.wdata[3:0], 2)) else $error("precharge wrong");
  AST_SS: assert property (s_wr(OFS_CHG_CUR) |->
    spread_spectrum_on_out == $past(req_in.wdata[3], 2)) else $error("spread spectrum wrong");
  AST_CHG: assert property (s_wr(OFS_EN_TEMP) |->
    charger_on_out == $past(req_in.wdata[4], 2)) else $error("charger enable wrong");
  AST_BATD: assert property (battery_detect_run_out |-> finish_current_cutoff_on_out)
    else $error("detection without termination");
endmodule
bind ccr_regs ccr_regs_checker i_ccr_regs_checker (.clk_in, .reset_n_in, .req_in, .rdata_out,
  .finish_current_cutoff_on_out, .battery_detect_run_out, .charger_on_out, .spread_spectrum_on_out,
  .soft_reset_out, .setpoints_out);

// file: sim/ccr_regs_tb_top.sv
// self-checking bench for the charger register bank
// assumes the host model drives the request port; all else is driven here
`timescale 1ns/10ps
module ccr_regs_tb_top;
  import ccr_pkg::*;
  localparam logic [7:0] TB_IDENT = 8'h3c; // arbitrary identity value
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  ccr_req_s req_in;
  ccr_evt_s evt_in = '0;
  logic [1:0] phase_in = 2'h0;
  logic [3:0] temp_zone_in = 4'h0;
  logic floor_active_in = 1'b0;
  logic boost_active_in = 1'b0;
  logic power_good_in = 1'b0;
  logic otg_pin_in = 1'b0;
  logic [4:0] avg_input_limit_code_in = 5'h0c; // 1200mA by code
  logic [2:0] usb_type_detect_result_in = 3'h0; // no type found
  logic [7:0] rdata_out;
  logic rvalid_out, irq_out, stat_pin_oe_out, finish_current_cutoff_on_out;
  logic battery_detect_run_out, charger_on_out, spread_spectrum_on_out, soft_reset_out;
  logic [2:0] path_sense_trim_out;
  ccr_set_s setpoints_out;
  int fails = 0;
  int comparisons = 0;
  always #10 clk_in = ~clk_in; // 50 MHz
  ccr_regs #(.IDENT_VALUE(TB_IDENT), .EVT_W(9)) i_ccr_regs (.clk_in, .reset_n_in, .req_in, .evt_in, .phase_in,
    .temp_zone_in, .floor_active_in, .boost_active_in, .power_good_in, .otg_pin_in, .avg_input_limit_code_in,
    .usb_type_detect_result_in, .rdata_out, .rvalid_out, .irq_out, .stat_pin_oe_out, .finish_current_cutoff_on_out,
    .battery_detect_run_out, .charger_on_out, .spread_spectrum_on_out, .soft_reset_out, .path_sense_trim_out,
    .setpoints_out);
  ccr_host_model host (.clk_in, .rvalid_in(rvalid_out), .rdata_in(rdata_out), .req_out(req_in));
  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one comparison, four-state exact
  task automatic chk(input string n, input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  // wait n edges, then step past them
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // read and compare; a missing answer ends the run
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      fails++;
      stop_test();
    end
    chk(n, {4'h0, d}, {4'h0, exp});
  endtask
  // reset values, identity and an unmapped place
  task automatic s_reset();
    logic [15:0] t [14] = '{16'h0140, 16'h0266, {8'h03, TB_IDENT}, 16'h0400, 16'h0593, 16'h0602, 16'h0730,
      16'h0800, 16'h0900, 16'h0a00, 16'h0b00, 16'h0c00, 16'h1c9c, 16'h3000};
    foreach (t[i]) rchk("reset value", t[i][15:8], t[i][7:0]);
    chk("charger on", charger_on_out, 1'b1);
  endtask
  // read-only places keep their contents
  task automatic s_access();
    host.wr(8'h1c, 8'h9f);
    tick(3);
    chk("sense trim", path_sense_trim_out, 3'h7);
    host.wr(8'h08, 8'hff);
    rchk("flags kept", 8'h08, 8'h00);
    host.wr(8'h0a, 8'hff);
    rchk("boost flags kept", 8'h0a, 8'h00);
    host.wr(8'h03, 8'h00);
    rchk("identity kept", 8'h03, TB_IDENT);
    host.wr(8'h0b, 8'ha5);
    rchk("mask written", 8'h0b, 8'ha5);
    host.wr(8'h0b, 8'h00);
  endtask
  // every code of the setpoint fields
  task automatic s_fields();
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h01, {c[2:0], 1'b0, c[0], 3'h0});
      host.wr(8'h06, {4'h0, c[0], c[2:0]});
      tick(3);
      chk("end current", setpoints_out.eoc_ma, 12'(100 + 50 * c));
      chk("termination", finish_current_cutoff_on_out, c[0]);
      chk("precharge level", setpoints_out.preth_mv, 12'(2000 + 200 * c));
      chk("spread", spread_spectrum_on_out, c[0]);
    end
    for (int c = 0; c < 16; c++) begin
      host.wr(8'h05, {2'b10, c[1:0], c[3:0]});
      tick(3);
      chk("precharge current", setpoints_out.prec_ma, 12'(100 + 50 * c));
      chk("system floor", setpoints_out.sysmin_mv, 12'(3500 + 100 * c[1:0]));
    end
  endtask
  // input limit from the pin, then from the code
  task automatic s_limit();
    host.wr(8'h01, 8'h40);
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_in);
      otg_pin_in <= p[0];
      tick(5);
      chk("pin limit", setpoints_out.in_lim_ma, p ? 12'd1000 : 12'd500);
    end
    host.wr(8'h01, 8'h44);
    tick(3);
    chk("code limit", setpoints_out.in_lim_ma, 12'd1200);
    @(posedge clk_in);
    usb_type_detect_result_in <= 3'h1;
    avg_input_limit_code_in <= 5'h03;
    tick(3);
    chk("typed limit", setpoints_out.in_lim_ma, 12'd500);
    @(posedge clk_in);
    usb_type_detect_result_in <= 3'h0;
    tick(3);
    chk("low code limit", setpoints_out.in_lim_ma, 12'd150);
  endtask
  // status bits, zones and the indicator pin
  task automatic s_status();
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_in);
      phase_in <= p[1:0];
      temp_zone_in <= 4'h1 << p;
      floor_active_in <= p[0];
      boost_active_in <= p[1];
      power_good_in <= ~p[0];
      otg_pin_in <= p[1];
      tick(4);
      rchk("status", 8'h00, {2'b01, p[1:0], p[1], ~p[0], p[1], p[0]});
      rchk("zones", 8'h07, {4'h3, 4'h1 << p});
      chk("indicator", stat_pin_oe_out, p == 1);
    end
    @(posedge clk_in);
    phase_in <= 2'h1;
    host.wr(8'h00, 8'h00);
    tick(4);
    chk("indicator off", stat_pin_oe_out, 1'b0);
    host.wr(8'h00, 8'h40);
    tick(4);
    chk("indicator on", stat_pin_oe_out, 1'b1);
  endtask
  // each event sets its flag and the interrupt, masking holds it back
  task automatic s_flags();
    logic [15:0] f [9] = '{16'h0880, 16'h0804, 16'h0802, 16'h0801, 16'h0940, 16'h0920, 16'h0910,
      16'h0a40, 16'h0a20};
    host.wr(8'h01, 8'h48);
    tick(3);
    chk("detect off", battery_detect_run_out, 1'b0);
    host.wr(8'h07, 8'h70);
    tick(3);
    chk("detect on", battery_detect_run_out, 1'b1);
    foreach (f[i]) begin
      @(posedge clk_in);
      evt_in <= ccr_evt_s'(9'h100 >> i);
      tick(6);
      chk("irq raised", irq_out, 1'b1);
      @(posedge clk_in);
      evt_in <= '0;
      tick(4);
      rchk("flag set", f[i][15:8], f[i][7:0]);
      rchk("flag clear", f[i][15:8], 8'h00);
      chk("irq clear", irq_out, 1'b0);
    end
    host.wr(8'h0b, 8'h82);
    @(posedge clk_in);
    evt_in <= 9'h140;
    tick(6);
    chk("irq masked", irq_out, 1'b0);
    @(posedge clk_in);
    evt_in <= '0;
    tick(4);
    rchk("masked flags", 8'h08, 8'h82);
    host.wr(8'h0b, 8'h00);
  endtask
  // soft reset: zero write ignored, one write restores defaults
  task automatic s_soft();
    logic seen;
    seen = 1'b0;
    host.wr(8'h02, 8'h12);
    host.wr(8'h07, 8'h20);
    host.wr(8'h04, 8'h00);
    tick(3);
    chk("charger off", charger_on_out, 1'b0);
    rchk("zero write", 8'h02, 8'h12);
    host.wr(8'h04, 8'h80);
    repeat (3) begin
      @(negedge clk_in);
      seen |= soft_reset_out === 1'b1;
    end
    chk("reset pulse", seen, 1'b1);
    rchk("defaults back", 8'h02, 8'h66);
    rchk("reset bit", 8'h04, 8'h00);
    chk("charger on again", charger_on_out, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    tick(2);
    s_reset();
    s_access();
    s_fields();
    s_limit();
    s_status();
    s_flags();
    s_soft();
    stop_test();
  end
  // cuts a hang short
  initial begin
    #1000000;
    fails++;
    stop_test();
  end
endmodule

// file: src/ccr_pkg.sv
// package for the charger control and status register bank
// assumes a byte-wide register port driven from an i2c target on the same clock
package ccr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_TERM_MODE = 8'h01;
  localparam logic [7:0] OFS_REG_VOLT = 8'h02;
  localparam logic [7:0] OFS_IDENT = 8'h03;
  localparam logic [7:0] OFS_SOFT_RST = 8'h04;
  localparam logic [7:0] OFS_SYS_PREC = 8'h05;
  localparam logic [7:0] OFS_CHG_CUR = 8'h06;
  localparam logic [7:0] OFS_EN_TEMP = 8'h07;
  localparam logic [7:0] OFS_FLAGS_A = 8'h08;
  localparam logic [7:0] OFS_FLAGS_B = 8'h09;
  localparam logic [7:0] OFS_FLAGS_BST = 8'h0a;
  localparam logic [7:0] OFS_MASK_A = 8'h0b;
  localparam logic [7:0] OFS_MASK_B = 8'h0c;
  localparam logic [7:0] OFS_MASK_BST = 8'h0d;
  localparam logic [7:0] OFS_PATH_SENSE = 8'h1c;
  // reset values
  localparam logic [7:0] RST_STATUS_CTL = 8'h40;
  localparam logic [7:0] RST_TERM_MODE = 8'h40;
  localparam logic [7:0] RST_REG_VOLT = 8'h66;
  localparam logic [7:0] RST_SYS_PREC = 8'h93;
  localparam logic [7:0] RST_CHG_CUR = 8'h02;
  localparam logic [7:0] RST_EN_TEMP = 8'h30;
  localparam logic [7:0] RST_PATH_SENSE = 8'h9c;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // writable bit masks per register; the flags A mask gates reads instead
  localparam logic [7:0] WMSK_STATUS = 8'hc0;
  localparam logic [7:0] WMSK_EN_TEMP = 8'hf0;
  localparam logic [7:0] WMSK_BST = 8'he0;
  localparam logic [7:0] WMSK_FLAGS_A = 8'hf7;
  // field positions
  localparam int POS_EOC_LSB = 5;
  localparam int POS_TERM_ON = 3;
  localparam int POS_LIM_SRC = 2;
  localparam int POS_SOFT_RST = 7;
  localparam int POS_SYSMIN_LSB = 4;
  localparam int POS_SS_ON = 3;
  localparam int POS_BATD_ON = 6;
  localparam int POS_CHG_ON = 4;
  localparam int POS_IND_ON = 6;
  // flag bit positions
  localparam int FA_DIE_HOT = 7;
  localparam int FA_EOC_TMR = 2;
  localparam int FA_SYS_UV = 1;
  localparam int FA_BAT_MISS = 0;
  localparam int FB_POOR_SRC = 6;
  localparam int FB_BAT_OV = 5;
  localparam int FB_CHG_DONE = 4;
  localparam int FC_BST_OL = 6;
  localparam int FC_BST_LOW = 5;
  // decoded quantities, milliamps and millivolts
  localparam logic [11:0] EOC_BASE_MA = 12'd100;
  localparam logic [11:0] EOC_STEP_MA = 12'd50;
  localparam logic [11:0] PREC_BASE_MA = 12'd100;
  localparam logic [11:0] PREC_STEP_MA = 12'd50;
  localparam logic [11:0] SYSMIN_BASE_MV = 12'd3500;
  localparam logic [11:0] SYSMIN_STEP_MV = 12'd100;
  localparam logic [11:0] PRETH_BASE_MV = 12'd2000;
  localparam logic [11:0] PRETH_STEP_MV = 12'd200;
  localparam logic [11:0] PIN_LIM_LO_MA = 12'd500;
  localparam logic [11:0] PIN_LIM_HI_MA = 12'd1000;
  // average input limit ladder: two low steps, a 500mA plateau, then 100mA per code
  localparam logic [11:0] AICR_MIN_MA = 12'd100;
  localparam logic [11:0] AICR_LOW_MA = 12'd150;
  localparam logic [11:0] AICR_STEP_MA = 12'd100;
  // identity value is arbitrary
  localparam logic [7:0] IDENT_DEFAULT = 8'h5a;
  // charge phase encoding
  localparam logic [1:0] PH_READY = 2'h0;
  localparam logic [1:0] PH_CHARGING = 2'h1;
  localparam logic [1:0] PH_DONE = 2'h2;
  localparam logic [1:0] PH_FAULT = 2'h3;

  // register access request from the i2c target
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccr_req_s;

  // hardware fault and event conditions, one level each
  typedef struct packed {
    logic die_hot;
    logic eoc_timer;
    logic sys_uv;
    logic bat_missing;
    logic poor_source;
    logic bat_ov;
    logic chg_done;
    logic boost_ol;
    logic boost_low;
  } ccr_evt_s;

  // decoded analog setpoints
  typedef struct packed {
    logic [11:0] eoc_ma;
    logic [11:0] prec_ma;
    logic [11:0] sysmin_mv;
    logic [11:0] preth_mv;
    logic [11:0] in_lim_ma;
  } ccr_set_s;
endpackage

// file: src/ccr_regs.sv
// charger control, status, flag and mask register bank
// assumes an i2c target on clk_in presents byte requests; pins and analog states are async
//
// Function
// - charge phase two-bit read-only field
// - end-charge current code 100mA plus 50mA steps
// - termination applies only when enable set
// - source bit 0: limit from otg pin
// - source bit 1: limit from code, usb type
// - soft reset write one acts, reads zero
// - precharge current code from 100mA upward
// - spread spectrum follows its enable bit
// - charger enable gates charging, resets one
// - four read-only battery temperature zone bits
// - die overheat sets its flag
// - end-charge timer expiry sets its flag
// - system undervoltage sets its flag
// - missing battery sets its flag
// - weak or low input sets flag
// - battery overvoltage and termination set flags
// - boost overload and low battery flags
// - mask bit one suppresses interrupt, flag still sets, resets zero; mask B ignores writes, so its bits stay zero
// - input voltage floor status read-only bit
// - battery detect needs both enables set
// - status pin driven only when enabled
`timescale 1ns/10ps
module ccr_regs
  import ccr_pkg::*;
#(
  parameter logic [7:0] IDENT_VALUE = IDENT_DEFAULT, // arbitrary identity value
  parameter int EVT_W = 9
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire ccr_req_s req_in,
  input wire ccr_evt_s evt_in,
  input wire logic [1:0] phase_in,
  input wire logic [3:0] temp_zone_in,
  input wire logic floor_active_in,
  input wire logic boost_active_in,
  input wire logic power_good_in,
  input wire logic otg_pin_in,
  input wire logic [4:0] avg_input_limit_code_in,
  input wire logic [2:0] usb_type_detect_result_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic irq_out,
  output logic stat_pin_oe_out,
  output logic finish_current_cutoff_on_out,
  output logic battery_detect_run_out,
  output logic charger_on_out,
  output logic spread_spectrum_on_out,
  output logic soft_reset_out,
  output logic [2:0] path_sense_trim_out,
  output ccr_set_s setpoints_out
);
  // elaboration check: the event bundle is fixed at nine conditions
  if (EVT_W != $bits(ccr_evt_s)) begin : g_bad_evt
    $error("event width must match the event bundle");
  end

  // synchronised pin and analog levels
  localparam int SYNC_W = 9 + 2 + 4 + 1 + 1 + 1 + 1;
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_lvl;
  ccr_evt_s evt_s;
  logic [1:0] phase_s;
  logic [3:0] zone_s;
  logic floor_s;
  logic boost_s;
  logic pgood_s;
  logic otg_s;

  assign sync_raw = {evt_in, phase_in, temp_zone_in, floor_active_in, boost_active_in,
                     power_good_in, otg_pin_in};
  assign {evt_s, phase_s, zone_s, floor_s, boost_s, pgood_s, otg_s} = sync_lvl;

  // every asynchronous level except the limit code and usb type passes two flops
  ccr_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(sync_raw),
    .sync_out(sync_lvl)
  );

  // control registers
  logic [7:0] status_ctl_ff; // only bits 7:6 are storage
  logic [7:0] term_mode_ff;
  logic [7:0] reg_volt_ff;
  logic [7:0] sys_prec_ff;
  logic [7:0] chg_cur_ff;
  logic [7:0] en_temp_ff; // only bits 7:4 are storage
  logic [7:0] path_sense_ff;
  logic [7:0] mask_a_ff;
  logic [7:0] mask_b_ff;
  logic [7:0] mask_bst_ff;
  // sticky flags
  logic [7:0] flags_a_ff;
  logic [7:0] flags_b_ff;
  logic [7:0] flags_bst_ff;
  logic [7:0] nxt_flags_a;
  logic [7:0] nxt_flags_b;
  logic [7:0] nxt_flags_bst;
  logic [7:0] set_a; // events seen this cycle, kept apart so a read cannot swallow them
  logic [7:0] set_b;
  logic [7:0] set_bst;
  logic soft_rst_ff;
  logic wr_en;
  logic rd_en;
  logic [7:0] rd_mux;

  assign wr_en = req_in.wr;
  assign rd_en = req_in.rd;

  // merge writable bits only, keep the rest
  function automatic logic [7:0] merge_w(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] wmsk);
    merge_w = (old_v & ~wmsk) | (new_v & wmsk);
  endfunction

  // linear code to quantity decode, shared by four fields
  function automatic logic [11:0] lin_dec(input logic [11:0] base, input logic [11:0] step,
                                          input logic [3:0] code);
    logic [15:0] prod;
    prod = 16'(step) * 16'(code);
    lin_dec = base + prod[11:0];
  endfunction

  // average input limit: two low steps, a 500mA plateau, then 100mA per code
  // limitation: the all-ones code (no limit) reads as the top of the ladder
  function automatic logic [11:0] aicr_dec(input logic [4:0] code);
    case (code[4:1])
      4'h0: aicr_dec = AICR_MIN_MA;
      4'h1: aicr_dec = AICR_LOW_MA;
      4'h2: aicr_dec = PIN_LIM_LO_MA;
      default: aicr_dec = 12'(code) * AICR_STEP_MA;
    endcase
  endfunction

  // writable control registers, one process for the plain ones
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status_ctl_ff <= RST_STATUS_CTL;
      term_mode_ff <= RST_TERM_MODE;
      reg_volt_ff <= RST_REG_VOLT;
      sys_prec_ff <= RST_SYS_PREC;
      chg_cur_ff <= RST_CHG_CUR;
      en_temp_ff <= RST_EN_TEMP;
      path_sense_ff <= RST_PATH_SENSE;
      mask_a_ff <= RST_ZERO;
      mask_b_ff <= RST_ZERO;
      mask_bst_ff <= RST_ZERO;
    end else if (soft_rst_ff) begin
      // reset mode puts parameters back to defaults
      term_mode_ff <= RST_TERM_MODE;
      reg_volt_ff <= RST_REG_VOLT;
      sys_prec_ff <= RST_SYS_PREC;
      chg_cur_ff <= RST_CHG_CUR;
      en_temp_ff <= RST_EN_TEMP;
    end else if (wr_en) begin
      case (req_in.addr)
        OFS_STATUS: status_ctl_ff <= merge_w(status_ctl_ff, req_in.wdata, WMSK_STATUS);
        OFS_TERM_MODE: term_mode_ff <= req_in.wdata;
        OFS_REG_VOLT: reg_volt_ff <= req_in.wdata;
        OFS_SYS_PREC: sys_prec_ff <= req_in.wdata;
        OFS_CHG_CUR: chg_cur_ff <= req_in.wdata;
        OFS_EN_TEMP: en_temp_ff <= merge_w(en_temp_ff, req_in.wdata, WMSK_EN_TEMP);
        OFS_PATH_SENSE: path_sense_ff <= req_in.wdata;
        OFS_MASK_A: mask_a_ff <= req_in.wdata;
        // second mask reads only; writes ignored
        OFS_MASK_BST: mask_bst_ff <= merge_w(mask_bst_ff, req_in.wdata, WMSK_BST);
        default: ; // read-only or unmapped: ignore
      endcase
    end
  end

  // soft reset: one-cycle pulse on a write of one, write of zero ignored
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= wr_en && (req_in.addr == OFS_SOFT_RST) && req_in.wdata[POS_SOFT_RST];
    end
  end

  // flag set logic; host writes never reach these
  always_comb begin
    set_a = RST_ZERO;
    set_b = RST_ZERO;
    set_bst = RST_ZERO;
    set_a[FA_DIE_HOT] = evt_s.die_hot;
    set_a[FA_EOC_TMR] = evt_s.eoc_timer;
    set_a[FA_SYS_UV] = evt_s.sys_uv;
    // missing battery only counts while detection runs
    set_a[FA_BAT_MISS] = evt_s.bat_missing & battery_detect_run_out;
    set_b[FB_POOR_SRC] = evt_s.poor_source;
    set_b[FB_BAT_OV] = evt_s.bat_ov;
    // termination only registers when enabled
    set_b[FB_CHG_DONE] = evt_s.chg_done & term_mode_ff[POS_TERM_ON];
    // boost faults only meaningful in boost operation
    set_bst[FC_BST_OL] = evt_s.boost_ol & boost_s;
    set_bst[FC_BST_LOW] = evt_s.boost_low & boost_s;
    nxt_flags_a = flags_a_ff | set_a;
    nxt_flags_b = flags_b_ff | set_b;
    nxt_flags_bst = flags_bst_ff | set_bst;
  end

  // sticky flags; cleared by the register read, a set in that cycle wins
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_a_ff <= RST_ZERO;
      flags_b_ff <= RST_ZERO;
      flags_bst_ff <= RST_ZERO;
    end else begin
      // a read clears, but a condition present in that cycle sets again
      flags_a_ff <= (rd_en && req_in.addr == OFS_FLAGS_A) ? set_a : nxt_flags_a;
      flags_b_ff <= (rd_en && req_in.addr == OFS_FLAGS_B) ? set_b : nxt_flags_b;
      flags_bst_ff <= (rd_en && req_in.addr == OFS_FLAGS_BST) ? set_bst : nxt_flags_bst;
    end
  end

  // read mux, status bits composed live from synchronised levels
  always_comb begin
    case (req_in.addr)
      OFS_STATUS: rd_mux = {status_ctl_ff[7:6], phase_s, boost_s, pgood_s, otg_s, floor_s};
      OFS_TERM_MODE: rd_mux = term_mode_ff;
      OFS_REG_VOLT: rd_mux = reg_volt_ff;
      OFS_IDENT: rd_mux = IDENT_VALUE;
      OFS_SOFT_RST: rd_mux = RST_ZERO;
      OFS_SYS_PREC: rd_mux = sys_prec_ff;
      OFS_CHG_CUR: rd_mux = chg_cur_ff;
      OFS_EN_TEMP: rd_mux = {en_temp_ff[7:4], zone_s};
      OFS_FLAGS_A: rd_mux = flags_a_ff & WMSK_FLAGS_A;
      OFS_FLAGS_B: rd_mux = flags_b_ff;
      OFS_FLAGS_BST: rd_mux = flags_bst_ff;
      OFS_MASK_A: rd_mux = mask_a_ff;
      OFS_MASK_B: rd_mux = mask_b_ff;
      OFS_MASK_BST: rd_mux = mask_bst_ff;
      OFS_PATH_SENSE: rd_mux = path_sense_ff;
      default: rd_mux = RST_ZERO; // unmapped reads zero
    endcase
  end

  // read data registered one cycle after the request
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= RST_ZERO;
      rvalid_out <= 1'b0;
    end else begin
      rdata_out <= rd_en ? rd_mux : rdata_out;
      rvalid_out <= rd_en;
    end
  end

  // interrupt: any flag whose mask bit is clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(nxt_flags_a & ~mask_a_ff) | |(nxt_flags_b & ~mask_b_ff)
               | |(nxt_flags_bst & ~mask_bst_ff);
    end
  end

  // control outputs from flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stat_pin_oe_out <= 1'b0;
      finish_current_cutoff_on_out <= 1'b0;
      battery_detect_run_out <= 1'b0;
      charger_on_out <= 1'b0;
      spread_spectrum_on_out <= 1'b0;
      soft_reset_out <= 1'b0;
      path_sense_trim_out <= 3'h0;
    end else begin
      // open drain status pin pulls low while charging and enabled
      stat_pin_oe_out <= status_ctl_ff[POS_IND_ON] && (phase_s == PH_CHARGING);
      finish_current_cutoff_on_out <= term_mode_ff[POS_TERM_ON];
      battery_detect_run_out <= term_mode_ff[POS_TERM_ON] & en_temp_ff[POS_BATD_ON];
      charger_on_out <= en_temp_ff[POS_CHG_ON];
      spread_spectrum_on_out <= chg_cur_ff[POS_SS_ON];
      soft_reset_out <= soft_rst_ff;
      path_sense_trim_out <= path_sense_ff[2:0];
    end
  end

  // decoded setpoints
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      setpoints_out <= '0;
    end else begin
      setpoints_out.eoc_ma <= lin_dec(EOC_BASE_MA, EOC_STEP_MA,
                                      {1'b0, term_mode_ff[POS_EOC_LSB +: 3]});
      setpoints_out.prec_ma <= lin_dec(PREC_BASE_MA, PREC_STEP_MA, sys_prec_ff[3:0]);
      setpoints_out.sysmin_mv <= lin_dec(SYSMIN_BASE_MV, SYSMIN_STEP_MV,
                                         {2'b00, sys_prec_ff[POS_SYSMIN_LSB +: 2]});
      setpoints_out.preth_mv <= lin_dec(PRETH_BASE_MV, PRETH_STEP_MV, {1'b0, chg_cur_ff[2:0]});
      if (!term_mode_ff[POS_LIM_SRC]) begin
        setpoints_out.in_lim_ma <= otg_s ? PIN_LIM_HI_MA : PIN_LIM_LO_MA;
      end else begin
        // usb type zero means no type known, code applies
        setpoints_out.in_lim_ma <= (usb_type_detect_result_in != 3'h0 && avg_input_limit_code_in < 5'h05)
                                   ? PIN_LIM_LO_MA
                                   : aicr_dec(avg_input_limit_code_in);
      end
    end
  end
endmodule

// file: src/ccr_sync.sv
// two-stage synchroniser for a bundle of pin levels
// assumes inputs are asynchronous to clk_in
`timescale 1ns/10ps
module ccr_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff; // first stage, read only by second
  // two flops; first stage never feeds logic
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
